/* File: rtl/rmii_phy_pkg.sv */
// Summary of operation
// [RL1] In serial mode the controller drives the frame sync high for one clock in every ten.
// [RL2] In reduced mode the frame sync input is ignored and changes nothing.
// [RL3] Each port raises carrier sense / data valid whenever its receive medium is not idle.
// [RL4] Receive dibits carry data only while carrier sense / data valid is high.
// [RL5] On a false carrier the carrier indication stays high as long as the activity lasts.
// [RL6] The carrier indication need not be aligned to the reference clock.
// [RL7] The MAC presents transmit dibits on the reference clock, bit 1 most significant.
// [RL8] While transmit enable is low, transmit data other than 00 is ignored and nothing is sent.
// [RL9] The MAC raises transmit enable with the first preamble dibit and holds it for the frame.
// [RL10] The MAC changes transmit enable only on the reference clock.
// [RL11] Receive dibits are driven on the reference clock with bit 1 most significant.
// [RL12] A detected frame error raises receive error for one or more clocks, changing on the clock.
// [RL13] The system supplies a continuous reference clock that times all data signals.
// [RL14] Four independent port slices share one clock, each with its own data and control.
// [RL15] With no frame being received, receive error is low and receive data is 00.
package rmii_phy_pkg;
    localparam int         NUM_PORTS    = 4;
    localparam int         DIBIT_W      = 2;
    localparam int         SYNC_STAGES  = 2;
    // Frame sync spacing in reference clocks
    localparam int         FRAME_CLKS   = 10;
    localparam logic [3:0] FRAME_LAST   = 4'h9;
    localparam logic [3:0] SLOT_RESET   = 4'h0;
    localparam logic [1:0] DIBIT_IDLE   = 2'h0;
endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* File: rtl/rmii_phy_data.sv */
`timescale 1ns/100ps
`default_nettype none
module rmii_phy_data (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    // Mode strap: high selects serial operation
    input  wire logic                 i_smii_mode,
    input  wire logic                 i_serial_frame_sync,
    // MAC side, per port
    input  wire logic [3:0]           i_tx_en,
    input  wire logic [7:0]           i_txd,
    output logic      [3:0]           o_crs_dv,
    output logic      [7:0]           o_rxd,
    output logic      [3:0]           o_rx_er,
    // Medium side, per port
    input  wire logic [3:0]           i_rx_carrier,
    input  wire logic [7:0]           i_rx_dibit,
    input  wire logic [3:0]           i_rx_valid,
    input  wire logic [3:0]           i_rx_err,
    output logic      [7:0]           o_tx_dibit,
    output logic      [3:0]           o_tx_valid,
    // Frame sync supervision
    output logic                      o_sync_locked,
    output logic                      o_sync_err
);
    localparam int NP = rmii_phy_pkg::NUM_PORTS;
    localparam int DW = rmii_phy_pkg::DIBIT_W;

    logic          rst_meta;
    logic          rst_n;
    logic [NP-1:0] carrier;
    logic          smii;
    logic          fsync;
    logic [3:0]    slot;

    // Reset asserts at once, releases after two clocks
    // Inputs sampled before the third clock after release are not forwarded
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Carrier comes from the analog receiver, not from this clock
    pin_sync #(.WIDTH(NP)) u_carrier_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n),
        .i_async (i_rx_carrier),
        .o_sync  (carrier)
    );

    pin_sync #(.WIDTH(2)) u_pin_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n),
        .i_async ({i_smii_mode, i_serial_frame_sync}),
        .o_sync  ({smii, fsync})
    );

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            // Carrier indication is the synchronised medium activity, so a false
            // carrier holds it for exactly as long as the activity lasts
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    o_crs_dv[p] <= 1'b0;
                end else begin
                    o_crs_dv[p] <= carrier[p]; // RL3 RL5 RL6
                end
            end

            // Data only inside carrier; idle dibit otherwise
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    o_rxd[p*DW +: DW] <= rmii_phy_pkg::DIBIT_IDLE;
                end else if (carrier[p] && i_rx_valid[p]) begin
                    o_rxd[p*DW +: DW] <= i_rx_dibit[p*DW +: DW]; // RL4 RL11
                end else begin
                    o_rxd[p*DW +: DW] <= rmii_phy_pkg::DIBIT_IDLE; // RL15
                end
            end

            // Error flagged per clock the decoder reports it, within the frame
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    o_rx_er[p] <= 1'b0;
                end else begin
                    o_rx_er[p] <= carrier[p] && i_rx_err[p]; // RL12 RL15
                end
            end

            // Stray data outside transmit enable never reaches the line
            // Registered so every output leaves a flop, at one clock of latency
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    o_tx_valid[p]          <= 1'b0;
                    o_tx_dibit[p*DW +: DW] <= rmii_phy_pkg::DIBIT_IDLE;
                end else begin
                    o_tx_valid[p]          <= i_tx_en[p];
                    o_tx_dibit[p*DW +: DW] <= i_tx_en[p] ? i_txd[p*DW +: DW]
                                                         : rmii_phy_pkg::DIBIT_IDLE; // RL8 RL14
                end
            end

            // Checks sit per slice, so a failure names its port by generate scope
            chk_rxd_idle: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL15
                !carrier[p] |=> (o_rxd[p*DW +: DW] == 2'h0) && !o_rx_er[p])
                else $error("receive data or error active outside carrier");

            chk_rx_data_pass: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL4
                carrier[p] && i_rx_valid[p] |=>
                    o_rxd[p*DW +: DW] == $past(i_rx_dibit[p*DW +: DW]))
                else $error("received dibit not passed to the MAC");

            // Three clocks of pin history cover both sync stages and the output flop
            chk_carrier_hold: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL5
                i_rx_carrier[p] [*3] |=> o_crs_dv[p])
                else $error("carrier indication dropped while medium active");

            chk_carrier_drop: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL3
                !i_rx_carrier[p] [*3] |=> !o_crs_dv[p])
                else $error("carrier indication held on an idle medium");

            chk_tx_quiet: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL8
                !i_tx_en[p] |=> !o_tx_valid[p] && (o_tx_dibit[p*DW +: DW] == 2'h0))
                else $error("transmit activity without transmit enable");

            chk_tx_pass: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL14
                i_tx_en[p] |=> o_tx_valid[p] &&
                    (o_tx_dibit[p*DW +: DW] == $past(i_txd[p*DW +: DW])))
                else $error("transmit dibit not forwarded on its port");

            chk_rx_err_flag: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL12
                carrier[p] && i_rx_err[p] |=> o_rx_er[p])
                else $error("receive error not reported");

            chk_rx_err_clear: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL12
                carrier[p] && !i_rx_err[p] |=> !o_rx_er[p])
                else $error("receive error raised without a decoder report");

            chk_rx_refused: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL4
                carrier[p] && !i_rx_valid[p] |=> (o_rxd[p*DW +: DW] == 2'h0))
                else $error("invalid receive dibit passed to the MAC");

            // The registered copy trails the synchronised carrier by exactly one clock
            chk_crs_follow: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL6
                1'b1 |=> o_crs_dv[p] == $past(carrier[p]))
                else $error("carrier indication does not track the medium");
        end
    endgenerate

    // Slot counter follows the frame sync in serial mode only. In reduced mode
    // the pin floats, so the slot counter, lock and error flags are held in reset.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            slot <= rmii_phy_pkg::SLOT_RESET;
        end else if (!smii) begin
            slot <= rmii_phy_pkg::SLOT_RESET; // RL2
        end else if (fsync || slot == rmii_phy_pkg::FRAME_LAST) begin
            slot <= rmii_phy_pkg::SLOT_RESET;
        end else begin
            slot <= slot + 4'h1;
        end
    end

    // Locked after the first pulse; an early or missing pulse is sticky until
    // serial mode is left, since it means the controller broke the cadence
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_sync_locked <= 1'b0;
            o_sync_err    <= 1'b0;
        end else if (!smii) begin
            o_sync_locked <= 1'b0; // RL2
            o_sync_err    <= 1'b0;
        end else begin
            if (fsync) begin
                o_sync_locked <= 1'b1;
            end
            if (o_sync_locked && (fsync != (slot == rmii_phy_pkg::FRAME_LAST))) begin
                o_sync_err <= 1'b1; // RL1
            end
        end
    end

    // The counter is checked too, so stale state cannot leak into serial mode
    chk_sync_ignored: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL2
        !smii |=> !o_sync_locked && !o_sync_err && (slot == 4'h0))
        else $error("frame sync has effect in reduced mode");

    chk_sync_cadence: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        smii && o_sync_locked && fsync && (slot != 4'h9) |=> o_sync_err)
        else $error("early frame sync not flagged");

    chk_sync_missing: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        smii && o_sync_locked && !fsync && (slot == 4'h9) |=> o_sync_err)
        else $error("missing frame sync not flagged");

    // Lock and error only ever fall together, when serial mode is left
    chk_sync_lock: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        smii && fsync |=> o_sync_locked)
        else $error("frame sync pulse did not lock");

    chk_lock_hold: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        smii && o_sync_locked |=> o_sync_locked)
        else $error("frame sync lock lost in serial mode");

    chk_err_sticky: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        smii && o_sync_err |=> o_sync_err)
        else $error("cadence error cleared in serial mode");

    chk_err_needs_lock: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        !o_sync_locked |-> !o_sync_err)
        else $error("cadence error without frame sync lock");

    chk_slot_range: assert property (@(posedge i_mclk) disable iff (!rst_n) // RL1
        slot <= rmii_phy_pkg::FRAME_LAST)
        else $error("slot counter beyond the last slot of a frame");
endmodule // rmii_phy_data
`default_nettype wire

/* File: tb/mac_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_model (
    input  wire logic       i_mclk,
    input  wire logic       i_start,
    input  wire logic       i_early,
    input  wire logic       i_late,
    output logic      [3:0] o_tx_en,
    output logic      [7:0] o_txd,
    output logic            o_sync
);
    logic [4:0] left = 5'h0;
    logic [3:0] slot = 4'h0;
    always_ff @(posedge i_mclk) begin
        left <= i_start ? 5'h10 : left - {4'h0, left != 5'h0};
    end
    // Early mode shortens and late mode stretches the sync period to provoke cadence faults
    always_ff @(posedge i_mclk) begin
        slot <= (slot >= (i_early ? 4'h8 : (i_late ? 4'ha : 4'h9))) ? 4'h0 : slot + 4'h1;
    end
    assign o_tx_en = {4{left != 5'h0}};
    // Idle dibits stay non-zero on purpose so the bench sees them dropped
    assign o_txd   = (left != 5'h0) ? {left[3:2], left[1:0], ~left[1:0], left[2:1]}
                                    : {4{slot[1:0] | 2'h1}};
    assign o_sync  = (slot == 4'h0);
endmodule // mac_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        mclk = 1'b0, rst_n = 1'b0, smii = 1'b0, start = 1'b0, early = 1'b0;
    logic [3:0]  carrier = 4'h0, valid = 4'h0, err = 4'h0, crs, rx_er, tx_v, tx_en, exp_v;
    logic [7:0]  dibit = 8'h0, rxd, tx_d, txd, exp_d;
    logic        sync, locked, sync_err;
    logic        late = 1'b0;
    int          mismatches = 0, n_tests = 0;
    logic [35:0] rows [5] = '{36'hff0e4fe40, 36'h5ffff5335, 36'hfa0fffcc0,
                              36'h0ff1b0000, 36'hff900f009};
    mac_model u_mac (.i_mclk(mclk), .i_start(start), .i_early(early), .i_late(late),
                     .o_tx_en(tx_en), .o_txd(txd), .o_sync(sync));
    rmii_phy_data u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_smii_mode(smii),
        .i_serial_frame_sync(sync), .i_tx_en(tx_en), .i_txd(txd), .o_crs_dv(crs),
        .o_rxd(rxd), .o_rx_er(rx_er), .i_rx_carrier(carrier), .i_rx_dibit(dibit),
        .i_rx_valid(valid), .i_rx_err(err), .o_tx_dibit(tx_d), .o_tx_valid(tx_v),
        .o_sync_locked(locked), .o_sync_err(sync_err));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Expected transmit side one edge after the partner's values
    always @(posedge mclk) begin
        exp_v <= tx_en;
        exp_d <= txd & {{2{tx_en[3]}}, {2{tx_en[2]}}, {2{tx_en[1]}}, {2{tx_en[0]}}};
    end
    always @(negedge mclk) begin
        chk(tx_d, exp_d);
        chk({4'h0, tx_v}, {4'h0, exp_v});
    end
    initial begin
        wait_clk(3);
        chk({crs, rx_er}, 8'h00);
        wait_clk(2);
        rst_n = 1'b1;
        wait_clk(4);
        start = 1'b1;
        wait_clk(1);
        start = 1'b0;
        for (int i = 0; i < 5; i++) begin
            {carrier, valid, err, dibit} = rows[i][35:16];
            wait_clk(4);
            chk({4'h0, crs}, {4'h0, rows[i][15:12]});
            chk(rxd, rows[i][11:4]);
            chk({4'h0, rx_er}, {4'h0, rows[i][3:0]});
        end
        carrier = 4'hf;
        valid = 4'h0;
        err = 4'h0;
        dibit = 8'h5a;
        wait_clk(2);
        repeat (24) begin
            wait_clk(1);
            chk({crs, rx_er}, 8'hf0);
            chk(rxd, 8'h00);
        end
        carrier = 4'h0;
        wait_clk(30);
        chk({6'h0, locked, sync_err}, 8'h00);
        smii = 1'b1;
        for (int k = 0; k < 40 && locked !== 1'b1; k++) wait_clk(1);
        chk({7'h0, locked}, 8'h01);
        if (locked === 1'b1) begin
            wait_clk(30);
            chk({6'h0, locked, sync_err}, 8'h02);
            early = 1'b1;
            wait_clk(14);
            early = 1'b0;
            chk({7'h0, sync_err}, 8'h01);
            smii = 1'b0;
            wait_clk(6);
            chk({6'h0, locked, sync_err}, 8'h00);
            smii = 1'b1;
            for (int k = 0; k < 40 && locked !== 1'b1; k++) wait_clk(1);
            chk({7'h0, locked}, 8'h01);
            if (locked === 1'b1) begin
                late = 1'b1;
                wait_clk(14);
                late = 1'b0;
                chk({6'h0, locked, sync_err}, 8'h03);
            end
            smii = 1'b0;
            wait_clk(6);
            chk({6'h0, locked, sync_err}, 8'h00);
        end
        carrier = 4'hf;
        err = 4'hf;
        wait_clk(4);
        chk({crs, rx_er}, 8'hff);
        rst_n = 1'b0;
        wait_clk(1);
        chk({crs, rx_er}, 8'h00);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
